// ---- pld_lock_ctrl.sv ----
// lock detector, watchdog, factory test mode and test reset with register slave
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module pld_lock_ctrl #(
  parameter int WDOG_DIV = pld_pkg::WDOG_DIV_DEFAULT,
  parameter int DIV_SEL_W = 4,
  parameter int SKEW_SEL_W = 4,
  parameter int FREQ_SEL_W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_clk_i,
  input wire logic return_clk_i,
  input wire logic pll_clk_i,
  input wire logic [1:0] output_mode_i,
  input wire logic [pld_pkg::NUM_BANKS-1:0] bank_disable_inputs_i,
  input wire logic [pld_pkg::NUM_BANKS-1:0] bank_invert_i,
  input wire logic [DIV_SEL_W-1:0] div_sel_i,
  input wire logic [SKEW_SEL_W-1:0] skew_sel_i,
  input wire logic [FREQ_SEL_W-1:0] freq_sel_i,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic lock_o,
  output logic pll_clk_o,
  output logic test_mode_o,
  output logic [pld_pkg::NUM_BANKS-1:0] bank_hiz_o,
  output logic [pld_pkg::NUM_BANKS-1:0] bank_hold_o,
  output logic fsm_preset_o,
  output logic [DIV_SEL_W+SKEW_SEL_W+FREQ_SEL_W-1:0] preset_value_o,
  output logic irq_o
);

  localparam int PRESET_W = DIV_SEL_W + SKEW_SEL_W + FREQ_SEL_W;
  localparam int DIV_W = (WDOG_DIV > 1) ? $clog2(WDOG_DIV) : 1;

  // refused at elaboration, the divider and status word cannot serve these
  if (WDOG_DIV < 2 || WDOG_DIV > 65536) begin : gen_bad_div
    $error("WDOG_DIV must lie between 2 and 65536");
  end
  if (PRESET_W > 32) begin : gen_bad_preset
    $error("select widths together must not exceed 32 bits");
  end

  // sampled clocks and edges
  logic ref_q;
  logic ret_q;
  wire ref_rise;
  wire ret_rise;

  // lock detector state
  pld_pkg::pld_lock_state_type lock_state;
  pld_pkg::pld_lock_state_type next_lock_state;
  logic [7:0] since_ref;
  logic [2:0] err_run;
  logic [5:0] good_run;
  logic [2:0] next_err_run;
  logic [5:0] next_good_run;
  wire phase_err;
  wire lose_lock;
  wire gain_lock;
  wire park;

  // watchdog
  logic [DIV_W-1:0] wdog_div_cnt;
  logic [15:0] wdog_cnt;
  wire wdog_tick;
  wire wdog_timeout;

  // test mode and test reset
  logic [2:0] test_edges;
  logic fsm_held;
  wire test_mode;
  wire test_reset_req;
  wire test_reset_done;

  // registers
  logic [31:0] ctrl;
  logic [pld_pkg::IRQ_BITS-1:0] irq_status;
  logic [pld_pkg::IRQ_BITS-1:0] irq_mask;
  logic [15:0] wdog_limit;
  logic [pld_pkg::IRQ_BITS-1:0] irq_events;
  wire det_en;

  // ---- edge sampling ----
  assign ref_rise = ref_clk_i & ~ref_q;
  assign ret_rise = return_clk_i & ~ret_q;

  // ---- test mode decode ----
  assign test_mode = (output_mode_i == pld_pkg::MODE_MID);
  assign test_reset_req = test_mode & bank_disable_inputs_i[pld_pkg::BANK4_IDX];
  // held state lasts until bank4 disable or mid level goes away
  assign test_reset_done = test_reset_req & ref_rise &
    (test_edges == 3'(pld_pkg::TEST_RESET_EDGES - 1)) & ~fsm_held;

  // ---- phase error ----
  // only the lag of the return edge behind the reference edge is measured
  assign phase_err = ~ref_rise & (since_ref >= 8'(pld_pkg::PHASE_WINDOW_CYC));

  // ---- watchdog ----
  // the timeout needs reference edges, so a dead reference never times out; return edges still count as phase errors
  assign wdog_tick = ref_rise & (wdog_div_cnt == DIV_W'(WDOG_DIV - 1));
  assign wdog_timeout = (lock_state == pld_pkg::PLD_LOCKED) & ~ret_rise &
    wdog_tick & (wdog_cnt >= wdog_limit);

  // ---- lock hysteresis ----
  assign det_en = ctrl[pld_pkg::CTRL_DET_EN_BIT];
  // the edge that completes the test reset parks the detector as well
  assign park = fsm_held | test_reset_done | ~det_en;
  assign lose_lock = (lock_state == pld_pkg::PLD_LOCKED) & ret_rise & phase_err &
    (err_run >= 3'(pld_pkg::LOCK_LOSS_ERRORS - 1));
  assign gain_lock = (lock_state == pld_pkg::PLD_UNLOCKED) & ret_rise & ~phase_err &
    (good_run >= 6'(pld_pkg::LOCK_GAIN_CYCLES - 1));

  always_comb begin
    next_lock_state = lock_state;
    next_err_run = err_run;
    next_good_run = good_run;
    if (ret_rise) begin
      // each run restarts when the opposite condition shows
      if (phase_err) begin
        next_good_run = 6'h00;
        next_err_run = (err_run == 3'h7) ? err_run : err_run + 3'h1;
      end else begin
        next_err_run = 3'h0;
        next_good_run = (good_run == 6'h3f) ? good_run : good_run + 6'h01;
      end
    end
    unique case (lock_state)
      pld_pkg::PLD_LOCKED: begin
        if (lose_lock || wdog_timeout) begin
          next_lock_state = pld_pkg::PLD_UNLOCKED;
          next_err_run = 3'h0;
          next_good_run = 6'h00;
        end
      end
      pld_pkg::PLD_UNLOCKED: begin
        if (gain_lock) begin
          next_lock_state = pld_pkg::PLD_LOCKED;
          next_err_run = 3'h0;
          next_good_run = 6'h00;
        end
      end
    endcase
    // forced state and disabled detector both park the detector unlocked
    if (park) begin
      next_lock_state = pld_pkg::PLD_UNLOCKED;
      next_err_run = 3'h0;
      next_good_run = 6'h00;
    end
  end

  // ---- interrupt events ----
  assign irq_events[pld_pkg::IRQ_LOCK_GAINED] = gain_lock & ~park;
  assign irq_events[pld_pkg::IRQ_LOCK_LOST] = lose_lock & ~park;
  assign irq_events[pld_pkg::IRQ_WDOG_TIMEOUT] = wdog_timeout & ~park;
  assign irq_events[pld_pkg::IRQ_TEST_RESET] = test_reset_done;

  // ---- bus decode ----
  wire bus_req;
  wire bus_take;
  wire sel_ctrl;
  wire sel_status;
  wire sel_irq_status;
  wire sel_irq_mask;
  wire sel_wdog;
  wire wr_ctrl;
  wire wr_irq_status;
  wire wr_irq_mask;
  wire wr_wdog;
  logic [31:0] read_mux;

  assign bus_req = avs_read | avs_write;
  // a request is answered at the edge after it first shows
  assign bus_take = bus_req & ~avs_waitrequest;
  assign sel_ctrl = (avs_address == pld_pkg::REG_CTRL);
  assign sel_status = (avs_address == pld_pkg::REG_STATUS);
  assign sel_irq_status = (avs_address == pld_pkg::REG_IRQ_STATUS);
  assign sel_irq_mask = (avs_address == pld_pkg::REG_IRQ_MASK);
  assign sel_wdog = (avs_address == pld_pkg::REG_WDOG_LIMIT);
  assign wr_ctrl = bus_take & avs_write & sel_ctrl;
  assign wr_irq_status = bus_take & avs_write & sel_irq_status;
  assign wr_irq_mask = bus_take & avs_write & sel_irq_mask;
  assign wr_wdog = bus_take & avs_write & sel_wdog;

  always_comb begin
    read_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      read_mux = {31'h0000_0000, ctrl[pld_pkg::CTRL_DET_EN_BIT]};
    end else if (sel_status) begin
      read_mux = {16'h0000, 2'h0, good_run, 1'b0, err_run,
        fsm_held, test_mode, (lock_state == pld_pkg::PLD_LOCKED), lock_o};
    end else if (sel_irq_status) begin
      read_mux = {28'h000_0000, irq_status};
    end else if (sel_irq_mask) begin
      read_mux = {28'h000_0000, irq_mask};
    end else if (sel_wdog) begin
      read_mux = {16'h0000, wdog_limit};
    end
  end

  // ---- bank gating ----
  logic [pld_pkg::NUM_BANKS-1:0] hold_req;
  logic [pld_pkg::NUM_BANKS-1:0] hiz_req;

  // bank disables have no effect in test mode, except bank4 test reset
  always_comb begin
    for (int b = 0; b < pld_pkg::NUM_BANKS; b++) begin
      hold_req[b] = ~test_mode & bank_disable_inputs_i[b] &
        (output_mode_i == pld_pkg::MODE_LOW);
      hiz_req[b] = test_reset_req | (~test_mode & bank_disable_inputs_i[b] &
        (output_mode_i == pld_pkg::MODE_HIGH));
    end
  end

  genvar g;
  generate
    for (g = 0; g < pld_pkg::NUM_BANKS; g++) begin : gen_bank
      pld_bank_gate u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .out_clk_i(pll_clk_o),
        .invert_i(bank_invert_i[g]),
        .hold_req_i(hold_req[g]),
        .hiz_req_i(hiz_req[g]),
        .hold_o(bank_hold_o[g]),
        .hiz_o(bank_hiz_o[g])
      );
    end
  endgenerate

  // ---- sampling, phase and watchdog counters ----
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_q <= 1'b0;
      ret_q <= 1'b0;
      since_ref <= 8'hff;
    end else begin
      ref_q <= ref_clk_i;
      ret_q <= return_clk_i;
      if (ref_rise) begin
        since_ref <= 8'h00;
      end else if (since_ref != 8'hff) begin
        since_ref <= since_ref + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_div_cnt <= '0;
      wdog_cnt <= 16'h0000;
    end else begin
      if (ref_rise) begin
        wdog_div_cnt <= wdog_tick ? '0 : wdog_div_cnt + DIV_W'(1);
      end
      if (ret_rise || fsm_held) begin
        wdog_cnt <= 16'h0000;
      end else if (wdog_tick && wdog_cnt != 16'hffff) begin
        wdog_cnt <= wdog_cnt + 16'h0001;
      end
    end
  end

  // ---- lock state ----
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_state <= pld_pkg::PLD_UNLOCKED;
      err_run <= 3'h0;
      good_run <= 6'h00;
      lock_o <= 1'b0;
    end else begin
      lock_state <= next_lock_state;
      err_run <= next_err_run;
      good_run <= next_good_run;
      lock_o <= (next_lock_state == pld_pkg::PLD_LOCKED);
    end
  end

  // ---- test mode path and test reset ----
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_edges <= 3'h0;
      fsm_held <= 1'b0;
      pll_clk_o <= 1'b0;
      test_mode_o <= 1'b0;
      fsm_preset_o <= 1'b0;
      preset_value_o <= '0;
    end else begin
      test_mode_o <= test_mode;
      // reference level stands in for the pll output in test mode
      pll_clk_o <= test_mode ? ref_clk_i : pll_clk_i;
      if (!test_reset_req) begin
        test_edges <= 3'h0;
        fsm_held <= 1'b0;
      end else if (test_reset_done) begin
        fsm_held <= 1'b1;
      end else if (ref_rise && !fsm_held) begin
        test_edges <= test_edges + 3'h1;
      end
      fsm_preset_o <= test_reset_done | (fsm_held & test_reset_req);
      if (test_reset_done || (fsm_held && test_reset_req)) begin
        preset_value_o <= {div_sel_i, skew_sel_i, freq_sel_i};
      end
    end
  end

  // ---- registers and bus answer ----
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= pld_pkg::CTRL_RESET;
      irq_mask <= pld_pkg::IRQ_MASK_RESET;
      wdog_limit <= pld_pkg::WDOG_LIMIT_RESET;
      irq_status <= '0;
      irq_o <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req && avs_waitrequest && avs_read) begin
        avs_readdata <= read_mux;
      end
      if (wr_ctrl) begin
        ctrl <= {31'h0000_0000, avs_writedata[pld_pkg::CTRL_DET_EN_BIT]};
      end
      if (wr_irq_mask) begin
        irq_mask <= avs_writedata[pld_pkg::IRQ_BITS-1:0];
      end
      if (wr_wdog) begin
        wdog_limit <= avs_writedata[15:0];
      end
      // a new event wins over a one written to clear it
      irq_status <= (irq_status &
        ~(wr_irq_status ? avs_writedata[pld_pkg::IRQ_BITS-1:0] : '0)) | irq_events;
      irq_o <= |(irq_status & irq_mask);
    end
  end

endmodule : pld_lock_ctrl

// ---- pld_pkg.sv ----
// constants and types shared by the lock detect and test control block
package pld_pkg;

  // clock figures
  localparam int CLK_PERIOD_PS = 20000;
  localparam int PHASE_WINDOW_PS = 250;
  // a window shorter than one cycle still costs one whole cycle
  localparam int PHASE_WINDOW_CYC_RAW = PHASE_WINDOW_PS / CLK_PERIOD_PS;
  localparam int PHASE_WINDOW_CYC = (PHASE_WINDOW_CYC_RAW < 1) ? 1 : PHASE_WINDOW_CYC_RAW;

  // lock hysteresis, test reset and watchdog divider counts
  localparam int LOCK_LOSS_ERRORS = 4;
  localparam int LOCK_GAIN_CYCLES = 32;
  localparam int TEST_RESET_EDGES = 5;
  localparam int WDOG_DIV_DEFAULT = 16;

  // three-level output state select encoding
  localparam logic [1:0] MODE_LOW = 2'h0;
  localparam logic [1:0] MODE_MID = 2'h1;
  localparam logic [1:0] MODE_HIGH = 2'h2;

  // bank layout: banks 1..4 then the return bank
  localparam int NUM_BANKS = 5;
  localparam int BANK4_IDX = 3;

  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
  localparam logic [4:0] REG_WDOG_LIMIT = 5'h10;

  // field positions
  localparam int CTRL_DET_EN_BIT = 0;
  localparam int IRQ_LOCK_GAINED = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_WDOG_TIMEOUT = 2;
  localparam int IRQ_TEST_RESET = 3;
  localparam int IRQ_BITS = 4;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [15:0] WDOG_LIMIT_RESET = 16'h0040;

  typedef enum logic {
    PLD_UNLOCKED,
    PLD_LOCKED
  } pld_lock_state_type;

endpackage : pld_pkg

// ---- pld_bank_gate.sv ----
// glitch-free hold-off and high impedance control for one output bank
`timescale 1ns/100ps
module pld_bank_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic out_clk_i,
  input wire logic invert_i,
  input wire logic hold_req_i,
  input wire logic hiz_req_i,
  output logic hold_o,
  output logic hiz_o
);

  logic out_clk_q;
  wire stop_edge;
  wire next_hold;

  // non-inverting stops after a falling edge, inverting after a rising edge
  assign stop_edge = invert_i ? (out_clk_i & ~out_clk_q) : (~out_clk_i & out_clk_q);
  // change only on the stop edge so no runt pulse leaves the bank
  assign next_hold = stop_edge ? hold_req_i : hold_o;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_clk_q <= 1'b0;
      hold_o <= 1'b0;
      hiz_o <= 1'b0;
    end else begin
      out_clk_q <= out_clk_i;
      hold_o <= next_hold;
      hiz_o <= hiz_req_i;
    end
  end

endmodule : pld_bank_gate

// ---- pld_lock_checker.sv ----
// concurrent checks on the lock detect and test control ports
`timescale 1ns/100ps
module pld_lock_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_clk_i,
  input wire logic [1:0] output_mode_i,
  input wire logic [4:0] bank_disable_inputs_i,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic lock_o,
  input wire logic pll_clk_o,
  input wire logic test_mode_o,
  input wire logic [4:0] bank_hiz_o,
  input wire logic fsm_preset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic mid = output_mode_i == pld_pkg::MODE_MID;
  wire logic tst_rst = mid && bank_disable_inputs_i[pld_pkg::BANK4_IDX];
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (bus_req |=> bus_ans) else $error("bus answer wrong");
  chk_test_entry: assert property (mid |=> test_mode_o) else $error("no test mode");
  chk_test_exit: assert property (!mid |=> !test_mode_o) else $error("stray test mode");
  chk_ref_pass: assert property (mid |=> pll_clk_o == $past(ref_clk_i))
    else $error("reference not passed");
  chk_test_hiz: assert property (tst_rst |=> &bank_hiz_o) else $error("outputs not hiz");
  chk_preset_edges: assert property ($rose(fsm_preset_o) |-> $past(tst_rst, 8))
    else $error("preset too early");
  chk_preset_unlock: assert property (fsm_preset_o |-> !lock_o) else $error("lock in preset");
  chk_preset_hold: assert property (fsm_preset_o && tst_rst |=> fsm_preset_o)
    else $error("preset dropped");
  chk_preset_release: assert property (!tst_rst |=> !fsm_preset_o)
    else $error("preset kept");
  chk_test_banks: assert property (mid && !tst_rst |=> bank_hiz_o == 5'h0)
    else $error("bank disable in test");
  chk_high_hiz: assert property (output_mode_i == pld_pkg::MODE_HIGH
    |=> bank_hiz_o == $past(bank_disable_inputs_i)) else $error("hiz mismatch");
endmodule : pld_lock_checker

bind pld_lock_ctrl pld_lock_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .ref_clk_i(ref_clk_i),
  .output_mode_i(output_mode_i), .bank_disable_inputs_i(bank_disable_inputs_i),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .lock_o(lock_o), .pll_clk_o(pll_clk_o), .test_mode_o(test_mode_o),
  .bank_hiz_o(bank_hiz_o), .fsm_preset_o(fsm_preset_o));

// ---- pld_clk_partner.sv ----
// board reference source and return clock wiring
`timescale 1ns/100ps
module pld_clk_partner (
  input wire logic clk_i,
  output logic ref_o,
  output logic ret_o
);
  initial begin
    ref_o = 1'b0;
    ret_o = 1'b0;
  end
  // kind 0 aligned, 1 return lags two cycles, 2 return absent
  task automatic ref_period(input int kind);
    @(posedge clk_i);
    ref_o <= 1'b1;
    ret_o <= kind == 0;
    @(posedge clk_i);
    @(posedge clk_i);
    ref_o <= 1'b0;
    ret_o <= kind == 1;
    repeat (3) @(posedge clk_i);
    ret_o <= 1'b0;
  endtask : ref_period
endmodule : pld_clk_partner

// ---- test_pld_lock_ctrl.sv ----
// self-checking bench for the lock detect and test control block
`timescale 1ns/100ps
module test_pld_lock_ctrl;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ref_clk_i, return_clk_i, avs_waitrequest, lock_o, pll_clk_o, test_mode_o;
  logic fsm_preset_o, irq_o;
  logic pll_clk_i = 1'b0;
  logic [1:0] output_mode_i = pld_pkg::MODE_HIGH;
  logic [4:0] bank_disable_inputs_i = 5'h0;
  logic [4:0] bank_invert_i = 5'h0;
  logic [3:0] div_sel_i = 4'h0;
  logic [3:0] skew_sel_i = 4'h0;
  logic [1:0] freq_sel_i = 2'h0;
  logic [4:0] avs_address = 5'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic [4:0] bank_hiz_o, bank_hold_o;
  logic [9:0] preset_value_o;
  int mismatches = 0;
  int compares = 0;
  int seed = 17262;
  int clean = 0;
  int err = 0;
  logic lk = 1'b0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) pll_clk_i <= ~pll_clk_i;
  pld_clk_partner prt_u (.clk_i(clk_i), .ref_o(ref_clk_i), .ret_o(return_clk_i));
  pld_lock_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ref_clk_i(ref_clk_i),
    .return_clk_i(return_clk_i), .pll_clk_i(pll_clk_i), .output_mode_i(output_mode_i),
    .bank_disable_inputs_i(bank_disable_inputs_i), .bank_invert_i(bank_invert_i),
    .div_sel_i(div_sel_i), .skew_sel_i(skew_sel_i), .freq_sel_i(freq_sel_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lock_o(lock_o), .pll_clk_o(pll_clk_o),
    .test_mode_o(test_mode_o), .bank_hiz_o(bank_hiz_o), .bank_hold_o(bank_hold_o),
    .fsm_preset_o(fsm_preset_o), .preset_value_o(preset_value_o), .irq_o(irq_o));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // request held until waitrequest is sampled low at a rising edge; a hang ends in the watchdog
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // one reference period plus the hysteresis model
  task automatic per(input int k);
    prt_u.ref_period(k);
    if (k == 0) begin
      clean++;
      err = 0;
      if (clean >= 32) lk = 1'b1;
    end else if (k == 1) begin
      err++;
      clean = 0;
      if (err >= 4) lk = 1'b0;
    end
    @(negedge clk_i);
    if (k < 2) chk("lock", 32'(lk), 32'(lock_o));
  endtask : per
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0);
      chk("reset reg", (i == 0) ? 32'h1 : (i == 4) ? 32'h40 : 32'h0, rd);
    end
    bus(1'b1, 5'h14, 32'hffff_ffff);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    repeat (31) per(0);
    per(1);
    repeat (32) per(0);
    bus(1'b0, pld_pkg::REG_IRQ_STATUS, 32'h0);
    chk("irq status", 32'h1, rd);
    chk("irq masked", 32'h0, 32'(irq_o));
    bus(1'b1, pld_pkg::REG_IRQ_MASK, 32'hf);
    repeat (2) @(negedge clk_i);
    chk("irq raised", 32'h1, 32'(irq_o));
    repeat (60) per(($random(seed) & 7) == 0);
    repeat (32) per(0);
    repeat (3) per(1);
    per(0);
    repeat (4) per(1);
    bus(1'b0, pld_pkg::REG_IRQ_STATUS, 32'h0);
    chk("lost irq", 32'h2, rd & 32'h2);
    repeat (32) per(0);
    bus(1'b1, pld_pkg::REG_WDOG_LIMIT, 32'h1);
    bus(1'b1, pld_pkg::REG_IRQ_STATUS, 32'hf);
    repeat (2) @(negedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    repeat (40) per(2);
    chk("watchdog", 32'h0, 32'(lock_o));
    bus(1'b0, pld_pkg::REG_IRQ_STATUS, 32'h0);
    chk("wdog irq", 32'h4, rd & 32'h4);
    // regain lock so the test reset has a locked detector to park
    lk = 1'b0;
    clean = 0;
    err = 0;
    repeat (32) per(0);
    @(posedge clk_i);
    div_sel_i <= 4'($random(seed));
    skew_sel_i <= 4'($random(seed));
    freq_sel_i <= 2'($random(seed));
    output_mode_i <= pld_pkg::MODE_MID;
    repeat (2) @(negedge clk_i);
    chk("test mode", 32'h1, 32'(test_mode_o));
    @(posedge clk_i);
    bank_disable_inputs_i <= 5'h08;
    repeat (2) @(negedge clk_i);
    chk("hiz all", 32'h1f, 32'(bank_hiz_o));
    repeat (4) per(2);
    chk("early preset", 32'h0, 32'(fsm_preset_o));
    per(2);
    chk("preset", 32'h1, 32'(fsm_preset_o));
    chk("preset lock", 32'h0, 32'(lock_o));
    chk("preset val", 32'({div_sel_i, skew_sel_i, freq_sel_i}), 32'(preset_value_o));
    repeat (3) per(2);
    chk("held", 32'h3f, 32'({fsm_preset_o, bank_hiz_o}));
    @(posedge clk_i);
    bank_disable_inputs_i <= 5'h0;
    repeat (2) @(negedge clk_i);
    chk("resume", 32'h40, 32'({test_mode_o, fsm_preset_o, bank_hiz_o}));
    bus(1'b0, pld_pkg::REG_IRQ_STATUS, 32'h0);
    chk("test irq", 32'h8, rd & 32'h8);
    @(posedge clk_i);
    output_mode_i <= pld_pkg::MODE_HIGH;
    bank_disable_inputs_i <= 5'($random(seed));
    repeat (2) @(negedge clk_i);
    chk("hiz high", 32'(bank_disable_inputs_i), 32'(bank_hiz_o));
    @(posedge clk_i);
    output_mode_i <= pld_pkg::MODE_LOW;
    bank_invert_i <= 5'($random(seed));
    bank_disable_inputs_i <= 5'h1f;
    // six output clocks of two cycles each, plus the register stage
    repeat (13) @(negedge clk_i);
    chk("hold", 32'h1f, 32'({bank_hiz_o, bank_hold_o}));
    @(posedge clk_i);
    bank_disable_inputs_i <= 5'h0;
    repeat (13) @(negedge clk_i);
    chk("enabled", 32'h0, 32'({bank_hiz_o, bank_hold_o}));
    end_sim;
  end
  initial begin
    #400000;
    mismatches++;
    end_sim;
  end
endmodule : test_pld_lock_ctrl
